/* File: verilog/swl_defines.svh */
// Register indices, field positions and reset values of the stop wake logic
`ifndef SWL_DEFINES_SVH
`define SWL_DEFINES_SVH

// Bus geometry: byte address, register index is address bits 13..2
`define SWL_ADDR_W          14
`define SWL_IDX_W           12
`define SWL_DATA_W          32

// Register indices (byte address is four times the index)
`define SWL_IDX_REF_STATUS  12'hF0A
`define SWL_IDX_P2_SELECT   12'hF0C
`define SWL_IDX_COMBO       12'hF0D
`define SWL_IDX_IRQ_STATUS  12'hF10
`define SWL_IDX_IRQ_CLEAR   12'hF11
`define SWL_IDX_IRQ_ENABLE  12'hF12

// Field positions
`define SWL_COMBO_LEVEL_BIT 6
`define SWL_COMBO_SRC_HI    4
`define SWL_COMBO_SRC_LO    2
`define SWL_IRQ_PIN_BIT     0
`define SWL_IRQ_COMBO_BIT   1
`define SWL_IRQ_W           2

// Reset values
`define SWL_P2_SELECT_RST   8'h00
`define SWL_COMBO_RST       8'h00
`define SWL_REF_VALUE_RST   8'h00
`define SWL_IRQ_RST         2'h0
`define SWL_READ_RST        32'h0000_0000

`endif

/* File: verilog/swl_pkg.sv */
// Types shared by the stop wake logic
`include "swl_defines.svh"

package swl_pkg;

	// Origin of the port 2 comparison reference
	typedef enum logic [1:0] {
		REF_NONE  = 2'b00,
		REF_READ  = 2'b01,
		REF_WRITE = 2'b10
	} swl_ref_type;

	// Gate combination selected by the combined wake source field
	typedef enum logic [2:0] {
		SRC_NONE       = 3'b000,
		SRC_NAND_P2LO  = 3'b001,
		SRC_NAND_P2ALL = 3'b010,
		SRC_NOR_P3     = 3'b011,
		SRC_NAND_P3    = 3'b100,
		SRC_NOR_P3P0   = 3'b101,
		SRC_NAND_P3P0  = 3'b110,
		SRC_NAND_P3P2  = 3'b111
	} swl_src_type;

	// Whole state of the wake core
	typedef struct packed {
		logic [7:0]               p2Select;
		logic                     comboLevel;
		swl_src_type              comboSrc;
		swl_ref_type              refStatus;
		logic [7:0]               refValue;
		logic [`SWL_IRQ_W-1:0]    irqStatus;
		logic [`SWL_IRQ_W-1:0]    irqEnable;
		logic                     waitReq;
		logic [`SWL_DATA_W-1:0]   readData;
		logic                     wakeReq;
		logic                     irqOut;
	} swl_state_type;

endpackage

/* File: verilog/swl_pin_sync.sv */
// Two flip-flop synchroniser for a group of pins
`timescale 1ns/1ps

module swl_pin_sync #(
	parameter int WIDTH = 20
) (
	input  wire logic             core_clk,  // Core clock
	input  wire logic             rst_b,     // Async reset, active low
	input  wire logic [WIDTH-1:0] pinsIn,    // Raw pin levels
	output logic      [WIDTH-1:0] pinsOut    // Synchronised levels
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} swl_sync_type;

	swl_sync_type st_reg;
	swl_sync_type st_next;

	// First stage feeds only the second stage
	always_comb begin
		st_next.stage1 = pinsIn;
		st_next.stage2 = st_reg.stage1;
	end

	// Stage registers
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign pinsOut = st_reg.stage2;

endmodule

/* File: verilog/swl_gate_combine.sv */
// Gate combinations of port 0, 2 and 3 pins for the combined wake source
`timescale 1ns/1ps

module swl_gate_combine (
	input  wire logic [1:0]        p0Pair,     // Port 0 pins {7,0}
	input  wire logic [7:0]        p2Pins,     // Port 2 pin levels
	input  wire logic [3:1]        p3Pins,     // Port 3 pins 3..1
	input  wire logic [1:0]        p0Use,      // Port 0 {7,0} usable as inputs
	input  wire logic [7:0]        p2Use,      // Port 2 pins usable
	input  wire logic [3:1]        p3Use,      // Port 3 pins usable
	input  wire swl_pkg::swl_src_type src,     // Selected combination
	output logic                   gateOut     // Combination result
);

	// Ignored pins act as the neutral value of the gate
	function automatic logic nandUse(input logic [15:0] v, input logic [15:0] u);
		return ~&(v | ~u);
	endfunction

	function automatic logic norUse(input logic [15:0] v, input logic [15:0] u);
		return ~|(v & u);
	endfunction

	logic [15:0] v3;
	logic [15:0] u3;

	// Port 2 pins alone, or port 3 group optionally widened by port 0 or port 2 pins
	always_comb begin
		v3 = {13'h0, p3Pins};
		u3 = {13'h0, p3Use};
		gateOut = 1'b0;
		case (src)
			swl_pkg::SRC_NAND_P2LO:  gateOut = nandUse({12'h000, p2Pins[3:0]}, {12'h000, p2Use[3:0]});
			swl_pkg::SRC_NAND_P2ALL: gateOut = nandUse({8'h00, p2Pins}, {8'h00, p2Use});
			swl_pkg::SRC_NOR_P3:     gateOut = norUse(v3, u3);
			swl_pkg::SRC_NAND_P3:    gateOut = nandUse(v3, u3);
			swl_pkg::SRC_NOR_P3P0:   gateOut = norUse({11'h0, p0Pair, p3Pins}, {11'h0, p0Use, p3Use});
			swl_pkg::SRC_NAND_P3P0:  gateOut = nandUse({11'h0, p0Pair, p3Pins}, {11'h0, p0Use, p3Use});
			swl_pkg::SRC_NAND_P3P2:  gateOut = nandUse({10'h0, p2Pins[2:0], p3Pins},
			                                           {10'h0, p2Use[2:0], p3Use});
			default:                 gateOut = 1'b0;
		endcase
	end

endmodule

/* File: verilog/swl_wake_core.sv */
// Stop-mode wake source logic with Avalon-MM register slave
`timescale 1ns/1ps
`include "swl_defines.svh"

// Notes on behaviour
// - Port 2 select bit enables that wake pin
// - No reference: selected pin wakes when zero
// - Port 2 data access captures selected reference
// - Captured reference: wake when pin differs
// - Reference status 01 read, 10 write
// - Writing 00 restores zero-level default
// - Wake selects survive stop recovery, reset only
// - Source field 4:2 selects; 000 none
// - Gate output matching level bit wakes
// - Gates ignore outputs and per-pin sources
// - Encodings 001 to 100 as listed
// - 101 NOR, 110 NAND with port 0
// - 111 NAND port 3 with port 2
// - Any enabled source causes recovery
// - Reference status never reads 11
module swl_wake_core (
	input  wire logic                   core_clk,        // Core clock, 40 MHz
	input  wire logic                   rst_b,           // Async reset, active low
	input  wire logic [`SWL_ADDR_W-1:0] avs_address,     // Byte address
	input  wire logic                   avs_read,        // Read request
	input  wire logic                   avs_write,       // Write request
	input  wire logic [`SWL_DATA_W-1:0] avs_writedata,   // Write data
	input  wire logic [3:0]             avs_byteenable,  // Byte lanes
	output logic      [`SWL_DATA_W-1:0] avs_readdata,    // Read data
	output logic                        avs_waitrequest, // Stall
	input  wire logic [7:0]             port0Pins,       // Port 0 pin levels
	input  wire logic [7:0]             port2Pins,       // Port 2 pin levels
	input  wire logic [3:0]             port3Pins,       // Port 3 pin levels
	input  wire logic [7:0]             port0IsOutput,   // Port 0 direction, 1 output
	input  wire logic [7:0]             port2IsOutput,   // Port 2 direction, 1 output
	input  wire logic [3:0]             port3IsOutput,   // Port 3 direction, 1 output
	input  wire logic [3:0]             port3WakeSelect, // Port 3 per-pin wake sources
	input  wire logic                   port2DataRead,   // Port 2 data read pulse
	input  wire logic                   port2DataWrite,  // Port 2 data write pulse
	input  wire logic [7:0]             port2DataValue,  // Value read or written
	output logic                        wakeRequest,     // Stop-mode wake request
	output logic                        irqOut           // Level interrupt
);

	swl_pkg::swl_state_type st_reg;
	swl_pkg::swl_state_type st_next;

	// Register index match on a word aligned byte address
	function automatic logic idxHit(input logic [`SWL_ADDR_W-1:0] a, input logic [`SWL_IDX_W-1:0] idx);
		return a[`SWL_ADDR_W-1:2] == idx;
	endfunction

	// Pins pass two flip-flops before use
	logic [19:0] pinsSync;
	logic [7:0]  p0s;
	logic [7:0]  p2s;
	logic [3:0]  p3s;

	swl_pin_sync #(
		.WIDTH (20)
	) u_sync (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.pinsIn   ({port0Pins, port2Pins, port3Pins}),
		.pinsOut  (pinsSync)
	);

	assign p0s = pinsSync[19:12];
	assign p2s = pinsSync[11:4];
	assign p3s = pinsSync[3:0];

	// Per-pin compare against zero or the captured reference
	logic [7:0] pinHit;
	logic       pinWake;

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (st_reg.refStatus == swl_pkg::REF_NONE) begin
				pinHit[i] = st_reg.p2Select[i] & ~p2s[i];
			end else begin
				pinHit[i] = st_reg.p2Select[i] & (p2s[i] ^ st_reg.refValue[i]);
			end
		end
		pinWake = |pinHit;
	end

	// Gate combination with exclusions
	logic [7:0] p2Use;
	logic [3:1] p3Use;
	logic [1:0] p0Use;
	logic       gateOut;
	logic       comboWake;

	assign p2Use = ~port2IsOutput & ~st_reg.p2Select;
	assign p3Use = ~port3IsOutput[3:1] & ~port3WakeSelect[3:1];
	assign p0Use = ~{port0IsOutput[7], port0IsOutput[0]};

	swl_gate_combine u_gate (
		.p0Pair  ({p0s[7], p0s[0]}),
		.p2Pins  (p2s),
		.p3Pins  (p3s[3:1]),
		.p0Use   (p0Use),
		.p2Use   (p2Use),
		.p3Use   (p3Use),
		.src     (st_reg.comboSrc),
		.gateOut (gateOut)
	);

	// no source when field is zero
	assign comboWake = (st_reg.comboSrc != swl_pkg::SRC_NONE) && (gateOut == st_reg.comboLevel);

	// Bus strobes
	logic busReq;
	logic wrEn;
	logic lane0;
	logic capture;
	logic [`SWL_IRQ_W-1:0] irqEvent;
	logic [`SWL_IRQ_W-1:0] irqClear;

	assign busReq = avs_read | avs_write;
	assign wrEn   = avs_write & ~st_reg.waitReq;
	assign lane0  = avs_byteenable[0];
	assign capture = (port2DataRead | port2DataWrite) & (|st_reg.p2Select);

	// Next state: registers, reference, interrupts and bus answer
	always_comb begin
		st_next  = st_reg;
		irqEvent = '0;
		irqClear = '0;

		// One wait cycle, then a single low cycle
		if (busReq && st_reg.waitReq) begin
			st_next.waitReq = 1'b0;
		end else begin
			st_next.waitReq = 1'b1;
		end

		// Read data prepared while the request waits
		if (avs_read && st_reg.waitReq) begin
			st_next.readData = `SWL_READ_RST;
			if (idxHit(avs_address, `SWL_IDX_REF_STATUS)) begin
				st_next.readData[1:0] = st_reg.refStatus;
			end else if (idxHit(avs_address, `SWL_IDX_IRQ_STATUS)) begin
				st_next.readData[`SWL_IRQ_W-1:0] = st_reg.irqStatus;
			end else if (idxHit(avs_address, `SWL_IDX_IRQ_ENABLE)) begin
				st_next.readData[`SWL_IRQ_W-1:0] = st_reg.irqEnable;
			end
		end

		// Register writes, low byte lane only
		if (wrEn && lane0) begin
			if (idxHit(avs_address, `SWL_IDX_P2_SELECT)) begin
				st_next.p2Select = avs_writedata[7:0];
			end else if (idxHit(avs_address, `SWL_IDX_COMBO)) begin
				st_next.comboLevel = avs_writedata[`SWL_COMBO_LEVEL_BIT];
				st_next.comboSrc   = swl_pkg::swl_src_type'(avs_writedata[`SWL_COMBO_SRC_HI:`SWL_COMBO_SRC_LO]);
			end else if (idxHit(avs_address, `SWL_IDX_REF_STATUS)) begin
				if (avs_writedata[1:0] == 2'h0) begin
					st_next.refStatus = swl_pkg::REF_NONE;
				end
			end else if (idxHit(avs_address, `SWL_IDX_IRQ_CLEAR)) begin
				irqClear = avs_writedata[`SWL_IRQ_W-1:0];
			end else if (idxHit(avs_address, `SWL_IDX_IRQ_ENABLE)) begin
				st_next.irqEnable = avs_writedata[`SWL_IRQ_W-1:0];
			end
		end

		// capture on port 2 data access
		if (capture) begin
			for (int i = 0; i < 8; i++) begin
				if (st_reg.p2Select[i]) begin
					st_next.refValue[i] = port2DataValue[i];
				end
			end
			if (port2DataWrite) begin
				st_next.refStatus = swl_pkg::REF_WRITE;
			end else begin
				st_next.refStatus = swl_pkg::REF_READ;
			end
		end

		st_next.wakeReq = pinWake | comboWake;

		// Sticky events, set wins over clear
		irqEvent[`SWL_IRQ_PIN_BIT]   = pinWake;
		irqEvent[`SWL_IRQ_COMBO_BIT] = comboWake;
		st_next.irqStatus = (st_reg.irqStatus & ~irqClear) | irqEvent;
		st_next.irqOut    = |(st_next.irqStatus & st_next.irqEnable);
	end

	// State register; only the core reset clears wake setup
	// kept across stop recovery
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg.p2Select   <= `SWL_P2_SELECT_RST;
			st_reg.comboLevel <= 1'b0;
			st_reg.comboSrc   <= swl_pkg::SRC_NONE;
			st_reg.refStatus  <= swl_pkg::REF_NONE;
			st_reg.refValue   <= `SWL_REF_VALUE_RST;
			st_reg.irqStatus  <= `SWL_IRQ_RST;
			st_reg.irqEnable  <= `SWL_IRQ_RST;
			st_reg.waitReq    <= 1'b1;
			st_reg.readData   <= `SWL_READ_RST;
			st_reg.wakeReq    <= 1'b0;
			st_reg.irqOut     <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from flip-flops
	assign avs_readdata    = st_reg.readData;
	assign avs_waitrequest = st_reg.waitReq;
	assign wakeRequest     = st_reg.wakeReq;
	assign irqOut          = st_reg.irqOut;

	// Bus answers one cycle after the request appears
	a_bus_answer: assert property (@(posedge core_clk) disable iff (!rst_b)
		busReq && avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest did not drop after one cycle");

	// Low waitrequest lasts one cycle only
	a_bus_release: assert property (@(posedge core_clk) disable iff (!rst_b)
		!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest stayed low");

	a_select_write: assert property (@(posedge core_clk) disable iff (!rst_b)
		wrEn && lane0 && idxHit(avs_address, `SWL_IDX_P2_SELECT)
		|=> st_reg.p2Select == $past(avs_writedata[7:0]))
		else $error("port 2 select write lost");

	a_zero_default: assert property (@(posedge core_clk) disable iff (!rst_b)
		st_reg.refStatus == swl_pkg::REF_NONE && (|(st_reg.p2Select & ~p2s))
		|=> wakeRequest)
		else $error("zero pin did not wake");

	a_ref_capture: assert property (@(posedge core_clk) disable iff (!rst_b)
		capture |=> ((st_reg.refValue ^ $past(port2DataValue)) & $past(st_reg.p2Select)) == 8'h00)
		else $error("reference not captured");

	a_ref_differs: assert property (@(posedge core_clk) disable iff (!rst_b)
		st_reg.refStatus != swl_pkg::REF_NONE && (|((p2s ^ st_reg.refValue) & st_reg.p2Select))
		|=> wakeRequest)
		else $error("differing pin did not wake");

	a_ref_origin: assert property (@(posedge core_clk) disable iff (!rst_b)
		capture |=> st_reg.refStatus == ($past(port2DataWrite) ? swl_pkg::REF_WRITE : swl_pkg::REF_READ))
		else $error("reference origin wrong");

	a_ref_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
		wrEn && lane0 && idxHit(avs_address, `SWL_IDX_REF_STATUS) && avs_writedata[1:0] == 2'h0 && !capture
		|=> st_reg.refStatus == swl_pkg::REF_NONE)
		else $error("reference status not cleared");

	a_ref_legal: assert property (@(posedge core_clk) disable iff (!rst_b)
		st_reg.refStatus != 2'b11)
		else $error("reference status reads 11");

	a_combo_none: assert property (@(posedge core_clk) disable iff (!rst_b)
		st_reg.comboSrc == swl_pkg::SRC_NONE && !pinWake |=> !wakeRequest)
		else $error("wake without any source");

	a_combo_level: assert property (@(posedge core_clk) disable iff (!rst_b)
		st_reg.comboSrc != swl_pkg::SRC_NONE && gateOut == st_reg.comboLevel |=> wakeRequest)
		else $error("gate match did not wake");

	a_wake_any: assert property (@(posedge core_clk) disable iff (!rst_b)
		wakeRequest |-> $past(pinWake) || $past(comboWake))
		else $error("wake without cause");

	a_irq_level: assert property (@(posedge core_clk) disable iff (!rst_b)
		irqOut == |(st_reg.irqStatus & st_reg.irqEnable))
		else $error("interrupt output mismatch");

	a_select_kept: assert property (@(posedge core_clk) disable iff (!rst_b)
		st_reg.p2Select != $past(st_reg.p2Select)
		|-> $past(wrEn && lane0 && idxHit(avs_address, `SWL_IDX_P2_SELECT)))
		else $error("port 2 select changed without a write");

	a_combo_kept: assert property (@(posedge core_clk) disable iff (!rst_b)
		{st_reg.comboLevel, st_reg.comboSrc} != $past({st_reg.comboLevel, st_reg.comboSrc})
		|-> $past(wrEn && lane0 && idxHit(avs_address, `SWL_IDX_COMBO)))
		else $error("combined setup changed without a write");

	a_gate_p2all: assert property (@(posedge core_clk) disable iff (!rst_b)
		st_reg.comboSrc == swl_pkg::SRC_NAND_P2ALL
		|-> gateOut == |(~p2s & ~port2IsOutput & ~st_reg.p2Select))
		else $error("port 2 full gate wrong");

	a_gate_p2low: assert property (@(posedge core_clk) disable iff (!rst_b)
		st_reg.comboSrc == swl_pkg::SRC_NAND_P2LO
		|-> gateOut == |(~p2s[3:0] & ~port2IsOutput[3:0] & ~st_reg.p2Select[3:0]))
		else $error("port 2 low gate wrong");

	a_gate_nor3: assert property (@(posedge core_clk) disable iff (!rst_b)
		st_reg.comboSrc == swl_pkg::SRC_NOR_P3
		|-> gateOut == !(|(p3s[3:1] & ~port3IsOutput[3:1] & ~port3WakeSelect[3:1])))
		else $error("port 3 gate wrong");

	a_gate_port0: assert property (@(posedge core_clk) disable iff (!rst_b)
		st_reg.comboSrc == swl_pkg::SRC_NOR_P3P0 |-> gateOut == !(|({p0s[7], p0s[0], p3s[3:1]}
			& ~{port0IsOutput[7], port0IsOutput[0], port3IsOutput[3:1] | port3WakeSelect[3:1]})))
		else $error("port 0 gate wrong");

	a_gate_port2: assert property (@(posedge core_clk) disable iff (!rst_b)
		st_reg.comboSrc == swl_pkg::SRC_NAND_P3P2 |-> gateOut == |(~{p2s[2:0], p3s[3:1]}
			& ~{port2IsOutput[2:0] | st_reg.p2Select[2:0], port3IsOutput[3:1] | port3WakeSelect[3:1]}))
		else $error("port 2 and 3 gate wrong");

	// Event sets status even when cleared
	a_irq_sticky: assert property (@(posedge core_clk) disable iff (!rst_b)
		irqEvent != 2'b00
		|=> (st_reg.irqStatus & $past(irqEvent)) == $past(irqEvent))
		else $error("interrupt event lost");

endmodule

/* File: verif/swl_pin_model.sv */
// Pin driver standing in for keys and sensors on the wake ports
`timescale 1ns/1ps

module swl_pin_model (
	input  wire logic       core_clk,  // Paces pin changes
	input  wire logic       slowMode,  // Lag each change one cycle
	input  wire logic [7:0] p0Want,    // Wanted port 0 levels
	input  wire logic [7:0] p2Want,    // Wanted port 2 levels
	input  wire logic [3:0] p3Want,    // Wanted port 3 levels
	output logic      [7:0] port0Pins, // Port 0 pins
	output logic      [7:0] port2Pins, // Port 2 pins
	output logic      [3:0] port3Pins  // Port 3 pins
);
	logic [19:0] lagged;

	// Keys move between clock edges, promptly or a cycle late
	always @(negedge core_clk) begin
		lagged <= {p0Want, p2Want, p3Want};
		{port0Pins, port2Pins, port3Pins} <= slowMode ? lagged : {p0Want, p2Want, p3Want};
	end
endmodule

/* File: verif/swl_wake_core_tb.sv */
// Self-checking bench for the stop wake source logic
`timescale 1ns/1ps
`include "swl_defines.svh"

module swl_wake_core_tb;
	typedef struct packed {
		logic [2:0] src;
		logic       lvl;
		logic [7:0] p0;
		logic [7:0] p2;
		logic [3:0] p3;
		logic       exp;
	} swl_row_type;

	logic                   core_clk;
	logic                   rst_b;
	logic [`SWL_ADDR_W-1:0] avs_address;
	logic                   avs_read;
	logic                   avs_write;
	logic [31:0]            avs_writedata;
	logic [3:0]             avs_byteenable;
	logic [31:0]            avs_readdata;
	logic                   avs_waitrequest;
	logic [7:0]             p0Want;
	logic [7:0]             p2Want;
	logic [3:0]             p3Want;
	logic                   slowMode;
	logic [7:0]             port0Pins;
	logic [7:0]             port2Pins;
	logic [3:0]             port3Pins;
	logic [7:0]             port2IsOutput;
	logic [7:0]             port0IsOutput;
	logic [3:0]             port3IsOutput;
	logic [3:0]             port3WakeSelect;
	logic                   port2DataRead;
	logic                   port2DataWrite;
	logic [7:0]             port2DataValue;
	logic                   wakeRequest;
	logic                   irqOut;
	logic [31:0]            rdVal;
	int                     errTotal;
	int                     numChecks;

	// Gate combinations: source, level, pins and expected wake
	swl_row_type rows [16] = '{
		'{3'h0, 1'h0, 8'h00, 8'h00, 4'h0, 1'h0}, '{3'h0, 1'h1, 8'hff, 8'hff, 4'hf, 1'h0},
		'{3'h1, 1'h0, 8'h00, 8'h0f, 4'h0, 1'h1}, '{3'h1, 1'h0, 8'h00, 8'hf7, 4'h0, 1'h0},
		'{3'h2, 1'h1, 8'h00, 8'hff, 4'h0, 1'h0}, '{3'h2, 1'h1, 8'h00, 8'h7f, 4'h0, 1'h1},
		'{3'h3, 1'h1, 8'h00, 8'h00, 4'h1, 1'h1}, '{3'h3, 1'h1, 8'h00, 8'h00, 4'h2, 1'h0},
		'{3'h4, 1'h0, 8'h00, 8'h00, 4'he, 1'h1}, '{3'h4, 1'h0, 8'h00, 8'h00, 4'hc, 1'h0},
		'{3'h5, 1'h1, 8'h7e, 8'h00, 4'h0, 1'h1}, '{3'h5, 1'h1, 8'h80, 8'h00, 4'h0, 1'h0},
		'{3'h6, 1'h0, 8'h81, 8'h00, 4'he, 1'h1}, '{3'h6, 1'h0, 8'h80, 8'h00, 4'he, 1'h0},
		'{3'h7, 1'h0, 8'h00, 8'h07, 4'he, 1'h1}, '{3'h7, 1'h0, 8'h00, 8'h06, 4'he, 1'h0}};

	swl_wake_core dut (
		.core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .port0Pins(port0Pins),
		.port2Pins(port2Pins), .port3Pins(port3Pins), .port0IsOutput(port0IsOutput),
		.port2IsOutput(port2IsOutput), .port3IsOutput(port3IsOutput), .port3WakeSelect(port3WakeSelect),
		.port2DataRead(port2DataRead), .port2DataWrite(port2DataWrite),
		.port2DataValue(port2DataValue), .wakeRequest(wakeRequest), .irqOut(irqOut));

	swl_pin_model pins (
		.core_clk(core_clk), .slowMode(slowMode), .p0Want(p0Want), .p2Want(p2Want), .p3Want(p3Want),
		.port0Pins(port0Pins), .port2Pins(port2Pins), .port3Pins(port3Pins));

	// Clock at 40 MHz
	initial begin
		core_clk = 1'h0;
		forever #12.5 core_clk = ~core_clk;
	end

	task automatic endOfTest;
		$display("Checks %0d, errors %0d", numChecks, errTotal);
		if (errTotal == 0 && numChecks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			errTotal++;
			$display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One register access, held until the stall drops
	task automatic busAcc(input logic wr, input logic [11:0] idx, input logic [7:0] d, input logic [3:0] be);
		int n;
		n = 0;
		avs_address    <= {idx, 2'h0};
		avs_writedata  <= {24'h00_0000, d};
		avs_byteenable <= be;
		avs_write      <= wr;
		avs_read       <= !wr;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'h0 && n < 20);
		rdVal = avs_readdata;
		avs_write <= 1'h0;
		avs_read  <= 1'h0;
		@(posedge core_clk);
		if (n >= 20) begin
			errTotal++;
			endOfTest();
		end
	endtask

	task automatic wr(input logic [11:0] idx, input logic [7:0] d);
		busAcc(1'h1, idx, d, 4'hf);
	endtask

	task automatic rd(input logic [11:0] idx);
		busAcc(1'h0, idx, 8'h00, 4'hf);
	endtask

	// Set port 2 pins, let them pass the synchroniser, check wake
	task automatic expWake(input logic [7:0] p2, input logic e);
		p2Want <= p2;
		repeat (6) @(posedge core_clk);
		chk({31'h0, wakeRequest}, {31'h0, e});
	endtask

	// One CPU access of the port 2 data register
	task automatic p2Access(input logic w, input logic [7:0] v);
		port2DataWrite <= w;
		port2DataRead  <= !w;
		port2DataValue <= v;
		@(posedge core_clk);
		port2DataWrite <= 1'h0;
		port2DataRead  <= 1'h0;
		@(posedge core_clk);
	endtask

	// Hang guard
	initial begin
		repeat (20000) @(posedge core_clk);
		errTotal++;
		endOfTest();
	end

	// Main sequence
	initial begin
		errTotal = 0;
		numChecks = 0;
		rst_b = 1'h0;
		{avs_address, avs_read, avs_write, avs_writedata, avs_byteenable} = '0;
		{p0Want, p2Want, p3Want, slowMode, port2IsOutput, port3WakeSelect} = '0;
		{port0IsOutput, port3IsOutput} = '0;
		{port2DataRead, port2DataWrite, port2DataValue} = '0;
		repeat (5) @(posedge core_clk);
		rst_b <= 1'h1;
		@(posedge core_clk);
		rd(`SWL_IDX_REF_STATUS);
		chk(rdVal, 32'h0000_0000);
		rd(12'h000);
		chk(rdVal, 32'h0000_0000);
		for (int i = 0; i < 16; i++) begin
			p0Want   <= rows[i].p0;
			p3Want   <= rows[i].p3;
			slowMode <= i[0];
			wr(`SWL_IDX_COMBO, {1'h0, rows[i].lvl, 1'h0, rows[i].src, 2'h0});
			expWake(rows[i].p2, rows[i].exp);
		end
		rd(`SWL_IDX_IRQ_STATUS);
		chk(rdVal, 32'h0000_0002);
		// Output pins and port 3 per-pin sources drop out of the gates
		wr(`SWL_IDX_COMBO, 8'h04);
		{p0Want, p3Want} <= 12'h000;
		port2IsOutput <= 8'h01;
		expWake(8'h0e, 1'h1);
		port2IsOutput <= 8'h00;
		expWake(8'h0e, 1'h0);
		wr(`SWL_IDX_COMBO, 8'h10);
		p3Want <= 4'hc;
		port3WakeSelect <= 4'h2;
		expWake(8'h00, 1'h1);
		port3WakeSelect <= 4'h0;
		port3IsOutput <= 4'h2;
		expWake(8'h00, 1'h1);
		port3IsOutput <= 4'h0;
		expWake(8'h00, 1'h0);
		wr(`SWL_IDX_COMBO, 8'h54);
		{p0Want, p3Want} <= 12'h800;
		port0IsOutput <= 8'h80;
		expWake(8'h00, 1'h1);
		port0IsOutput <= 8'h00;
		expWake(8'h00, 1'h0);
		p2Want <= 8'hff;
		wr(`SWL_IDX_COMBO, 8'h00);
		wr(`SWL_IDX_IRQ_CLEAR, 8'h03);
		port2IsOutput <= 8'h00;
		wr(`SWL_IDX_P2_SELECT, 8'h01);
		expWake(8'hff, 1'h0);
		rd(`SWL_IDX_IRQ_STATUS);
		chk(rdVal, 32'h0000_0000);
		expWake(8'h01, 1'h0);
		wr(`SWL_IDX_IRQ_ENABLE, 8'h01);
		chk({31'h0, irqOut}, 32'h0000_0000);
		expWake(8'hfe, 1'h1);
		chk({31'h0, irqOut}, 32'h0000_0001);
		wr(`SWL_IDX_IRQ_ENABLE, 8'h00);
		repeat (2) @(posedge core_clk);
		chk({31'h0, irqOut}, 32'h0000_0000);
		wr(`SWL_IDX_IRQ_ENABLE, 8'h01);
		expWake(8'hff, 1'h0);
		wr(`SWL_IDX_IRQ_CLEAR, 8'h01);
		repeat (2) @(posedge core_clk);
		chk({31'h0, irqOut}, 32'h0000_0000);
		// Reference taken from data register accesses
		p2Access(1'h1, 8'h01);
		rd(`SWL_IDX_REF_STATUS);
		chk(rdVal, 32'h0000_0002);
		expWake(8'hff, 1'h0);
		expWake(8'hfe, 1'h1);
		p2Access(1'h0, 8'h00);
		rd(`SWL_IDX_REF_STATUS);
		chk(rdVal, 32'h0000_0001);
		expWake(8'hfe, 1'h0);
		expWake(8'hff, 1'h1);
		wr(`SWL_IDX_REF_STATUS, 8'h03);
		rd(`SWL_IDX_REF_STATUS);
		chk(rdVal, 32'h0000_0001);
		wr(`SWL_IDX_REF_STATUS, 8'h00);
		rd(`SWL_IDX_REF_STATUS);
		chk(rdVal, 32'h0000_0000);
		expWake(8'hff, 1'h0);
		expWake(8'hfe, 1'h1);
		// Lane 0 disabled write, write-only select
		busAcc(1'h1, `SWL_IDX_IRQ_ENABLE, 8'h02, 4'h0);
		rd(`SWL_IDX_IRQ_ENABLE);
		chk(rdVal, 32'h0000_0001);
		rd(`SWL_IDX_P2_SELECT);
		chk(rdVal, 32'h0000_0000);
		// Mid-run reset clears setup, reference and outputs
		p2Access(1'h1, 8'h01);
		rst_b <= 1'h0;
		repeat (2) @(posedge core_clk);
		chk({30'h0, avs_waitrequest, wakeRequest}, 32'h0000_0002);
		chk({31'h0, irqOut}, 32'h0000_0000);
		rst_b <= 1'h1;
		@(posedge core_clk);
		rd(`SWL_IDX_REF_STATUS);
		chk(rdVal, 32'h0000_0000);
		expWake(8'hfe, 1'h0);
		endOfTest();
	end
endmodule
